/* File: ssm_chk_properties.sv */
// Checker for the framer register port and line-side timing
`timescale 1ns/10ps
module ssm_chk_properties (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic rx_frame_i,
  input wire logic rx_mf_start_i,
  input wire logic tx_frame_i,
  input wire logic tx_mf_start_i,
  input wire logic rx_crc_multiframe_flag_o,
  input wire logic tx_multiframe_flag_o,
  input wire logic [4:0] tx_sa_o,
  input wire logic [4:0] tx_sa_en_o,
  input wire logic tx_si_en_o,
  input wire logic tx_ra_en_o
);
  logic [7:0] shadow_r [6];
  logic [7:0] rd_addr_r;
  logic [7:0] ctrl_w;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Mirror of host writes to the source and control bytes
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < 6; k++) shadow_r[k] <= 8'h00;
    end else if (reg_wr && reg_addr >= 8'hd5 && reg_addr <= 8'hda) begin
      shadow_r[3'(reg_addr - 8'hd5)] <= reg_wdata;
    end
  end
  // Address of the read in flight
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rd_addr_r <= 8'h00;
    end else if (reg_rd) begin
      rd_addr_r <= reg_addr;
    end
  end
  assign ctrl_w = shadow_r[5];
  //////////////////////////////////////////////////////////////////////////////
  sequence rx_mf_s;
    rx_frame_i && rx_mf_start_i;
  endsequence
  sequence tx_mf_s;
    tx_frame_i && tx_mf_start_i;
  endsequence
  rd_answer_a:
    assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  rvalid_cause_a:
    assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray read answer");
  src_readback_a:
    assert property (reg_rvalid && rd_addr_r >= 8'hd5 && rd_addr_r <= 8'hda
      |-> reg_rdata == shadow_r[3'(rd_addr_r - 8'hd5)]) else $error("readback differs");
  rx_flag_a:
    assert property (rx_mf_s |=> rx_crc_multiframe_flag_o) else $error("rx flag missing");
  rx_flag_cause_a:
    assert property (rx_crc_multiframe_flag_o |-> $past(rx_frame_i) && $past(rx_mf_start_i))
      else $error("rx flag without boundary");
  tx_flag_a:
    assert property (tx_mf_s |=> tx_multiframe_flag_o) else $error("tx flag missing");
  tx_hold_a:
    assert property (!tx_frame_i |=> $stable(tx_sa_o) && $stable(tx_sa_en_o))
      else $error("tx bits moved between frames");
  sa_enable_a:
    assert property (tx_mf_s |=> tx_sa_en_o == ctrl_w[4:0]) else $error("sa enable wrong");
  alarm_intl_en_a:
    assert property (tx_mf_s |=> tx_ra_en_o == ctrl_w[5] && tx_si_en_o == ctrl_w[6])
      else $error("alarm or intl enable wrong");
endmodule

/* File: ssm_framer_dev.sv */
// Spare-bit capture and insertion end of the E1 framer
`timescale 1ns/10ps
module ssm_framer_dev
  import ssm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  ssm_reg_if.device regs,
  input wire logic rx_frame_i,
  input wire logic rx_mf_start_i,
  input wire logic [ssm_pkg::SA_N-1:0] rx_sa_i,
  input wire logic tx_frame_i,
  input wire logic tx_mf_start_i,
  output logic [ssm_pkg::SA_N-1:0] tx_sa_o,
  output logic [ssm_pkg::SA_N-1:0] tx_sa_en_o,
  output logic tx_si_o,
  output logic tx_si_en_o,
  output logic tx_ra_o,
  output logic tx_ra_en_o,
  output logic rx_crc_multiframe_flag_o,
  output logic tx_multiframe_flag_o,
  output logic [7:0] master_mode_o,
  output logic [7:0] rx_ctrl_one_o,
  output logic [7:0] tx_ctrl_one_o,
  output logic [7:0] tx_align_word_o,
  output logic [7:0] tx_nonalign_word_o
);
  import ssm_pkg::*;

  logic [7:0] master_mode_r;
  logic [7:0] rx_ctrl_r;
  logic [7:0] tx_ctrl_r;
  logic [7:0] taf_r;
  logic [7:0] tx_nonalign_frame_word_r;
  logic [7:0] si_af_r;
  logic [7:0] si_naf_r;
  logic [7:0] ra_r;
  logic [7:0] ins_ctrl_r;
  logic [7:0] tx_src_r [SA_N];
  logic [7:0] rx_stage_r [SA_N];
  logic [7:0] rx_cap_r [SA_N];
  logic [7:0] tx_shadow_r [SA_N];
  logic [7:0] si_af_sh_r;
  logic [7:0] si_naf_sh_r;
  logic [7:0] ra_sh_r;
  logic [7:0] ins_sh_r;
  logic [3:0] rx_idx_r;
  logic [3:0] tx_idx_r;
  logic [3:0] rx_idx_nxt;
  logic [3:0] tx_idx_nxt;
  logic [2:0] rx_pos;
  logic [2:0] tx_pos;
  logic rx_mf_ev;
  logic tx_mf_ev;
  logic [1:0] status_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic [7:0] cap_idx;
  logic [7:0] src_idx;
  logic wr_src;
  logic rd_cap;
  logic rd_src;

  ////////////////////////////////////////////////////////////////////////////
  // Frame position bookkeeping

  assign rx_mf_ev = rx_frame_i && rx_mf_start_i;
  assign tx_mf_ev = tx_frame_i && tx_mf_start_i;
  // Multiframe start forces frame 1 (index 0)
  assign rx_idx_nxt = rx_mf_start_i ? 4'h0 : rx_idx_r + 4'h1;
  assign tx_idx_nxt = tx_mf_start_i ? 4'h0 : tx_idx_r + 4'h1;
  // Frame 1 maps to bit 7, frame 15 to bit 0
  assign rx_pos = 3'h7 - rx_idx_nxt[3:1];
  assign tx_pos = 3'h7 - tx_idx_nxt[3:1];

  // Frame counters
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_idx_r <= 4'h0;
      tx_idx_r <= 4'h0;
    end else if (ce_i) begin
      if (rx_frame_i) begin
        rx_idx_r <= rx_idx_nxt;
      end
      if (tx_frame_i) begin
        tx_idx_r <= tx_idx_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive capture

  // Odd frames fill staging; boundary copies whole words at once
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (int p = 0; p < SA_N; p++) begin
        rx_stage_r[p] <= REG_RESET;
        rx_cap_r[p] <= REG_RESET;
      end
    end else if (ce_i && rx_frame_i) begin
      for (int p = 0; p < SA_N; p++) begin
        if (rx_mf_ev) begin
          rx_cap_r[p] <= rx_stage_r[p];
        end
        if (!rx_idx_nxt[0]) begin
          rx_stage_r[p][rx_pos] <= rx_sa_i[SA_N-1-p];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit sampling and insertion

  // Sources and control sampled at the transmit multiframe boundary
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (int p = 0; p < SA_N; p++) begin
        tx_shadow_r[p] <= REG_RESET;
      end
      si_af_sh_r <= REG_RESET;
      si_naf_sh_r <= REG_RESET;
      ra_sh_r <= REG_RESET;
      ins_sh_r <= REG_RESET;
    end else if (ce_i && tx_mf_ev) begin
      for (int p = 0; p < SA_N; p++) begin
        tx_shadow_r[p] <= tx_src_r[p];
      end
      si_af_sh_r <= si_af_r;
      si_naf_sh_r <= si_naf_r;
      ra_sh_r <= ra_r;
      ins_sh_r <= ins_ctrl_r;
    end
  end

  // Per-frame overhead outputs; boundary frame uses live registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_sa_o <= '0;
      tx_sa_en_o <= '0;
      tx_si_o <= 1'b0;
      tx_si_en_o <= 1'b0;
      tx_ra_o <= 1'b0;
      tx_ra_en_o <= 1'b0;
    end else if (ce_i && tx_frame_i) begin
      for (int p = 0; p < SA_N; p++) begin
        tx_sa_o[SA_N-1-p] <= tx_mf_ev ? tx_src_r[p][tx_pos] : tx_shadow_r[p][tx_pos];
        tx_sa_en_o[SA_N-1-p] <= !tx_idx_nxt[0] &&
          (tx_mf_ev ? ins_ctrl_r[INS_SA_MSB-p] : ins_sh_r[INS_SA_MSB-p]);
      end
      if (!tx_idx_nxt[0]) begin
        tx_si_o <= tx_mf_ev ? si_naf_r[tx_pos] : si_naf_sh_r[tx_pos];
        tx_si_en_o <= tx_mf_ev ? ins_ctrl_r[INS_SI_NONALIGN_BIT] : ins_sh_r[INS_SI_NONALIGN_BIT];
        tx_ra_o <= tx_mf_ev ? ra_r[tx_pos] : ra_sh_r[tx_pos];
        tx_ra_en_o <= tx_mf_ev ? ins_ctrl_r[INS_RA_BIT] : ins_sh_r[INS_RA_BIT];
      end else begin
        tx_si_o <= si_af_sh_r[tx_pos];
        tx_si_en_o <= ins_sh_r[INS_SI_ALIGN_BIT];
        tx_ra_o <= 1'b0;
        tx_ra_en_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event pulses and sticky status

  // One-cycle boundary pulses
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_crc_multiframe_flag_o <= 1'b0;
      tx_multiframe_flag_o <= 1'b0;
    end else if (ce_i) begin
      rx_crc_multiframe_flag_o <= rx_mf_ev;
      tx_multiframe_flag_o <= tx_mf_ev;
    end
  end

  // Sticky flags, write one to clear, a new event wins
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      status_r <= 2'b00;
    end else if (ce_i) begin
      if (rx_mf_ev) begin
        status_r[0] <= 1'b1;
      end else if (regs.reg_wr && regs.reg_addr == STATUS_ADDR &&
                   regs.reg_wdata[STAT_RX_MF_BIT]) begin
        status_r[0] <= 1'b0;
      end
      if (tx_mf_ev) begin
        status_r[1] <= 1'b1;
      end else if (regs.reg_wr && regs.reg_addr == STATUS_ADDR &&
                   regs.reg_wdata[STAT_TX_MF_BIT]) begin
        status_r[1] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  assign cap_idx = regs.reg_addr - RX_CAPTURE_FIRST;
  assign src_idx = regs.reg_addr - TX_SOURCE_FIRST;
  assign rd_cap = regs.reg_addr >= RX_CAPTURE_FIRST && regs.reg_addr <= RX_CAPTURE_LAST;
  assign rd_src = regs.reg_addr >= TX_SOURCE_FIRST && regs.reg_addr <= TX_SOURCE_LAST;
  assign wr_src = regs.reg_wr && rd_src;

  // Host writes; captures ignore them
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      master_mode_r <= REG_RESET;
      rx_ctrl_r <= REG_RESET;
      tx_ctrl_r <= REG_RESET;
      taf_r <= REG_RESET;
      tx_nonalign_frame_word_r <= REG_RESET;
      si_af_r <= REG_RESET;
      si_naf_r <= REG_RESET;
      ra_r <= REG_RESET;
      ins_ctrl_r <= REG_RESET;
      for (int p = 0; p < SA_N; p++) begin
        tx_src_r[p] <= REG_RESET;
      end
    end else if (ce_i && regs.reg_wr) begin
      if (wr_src) begin
        tx_src_r[src_idx[2:0]] <= regs.reg_wdata;
      end
      unique case (regs.reg_addr)
        MASTER_MODE_ADDR: master_mode_r <= regs.reg_wdata;
        RX_CTRL_ONE_ADDR: rx_ctrl_r <= regs.reg_wdata;
        TX_CTRL_ONE_ADDR: tx_ctrl_r <= regs.reg_wdata;
        TX_ALIGN_WORD_ADDR: taf_r <= regs.reg_wdata;
        TX_NONALIGN_WORD_ADDR: tx_nonalign_frame_word_r <= regs.reg_wdata;
        TX_INTL_ALIGN_ADDR: si_af_r <= regs.reg_wdata;
        TX_INTL_NONALIGN_ADDR: si_naf_r <= regs.reg_wdata;
        TX_REMOTE_ALARM_ADDR: ra_r <= regs.reg_wdata;
        TX_INSERT_CTRL_ADDR: ins_ctrl_r <= regs.reg_wdata;
        default: ;
      endcase
    end
  end

  // Read answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_r <= REG_RESET;
      rvalid_r <= 1'b0;
    end else if (ce_i) begin
      rvalid_r <= regs.reg_rd;
      if (regs.reg_rd) begin
        if (rd_cap) begin
          rdata_r <= rx_cap_r[cap_idx[2:0]];
        end else if (rd_src) begin
          rdata_r <= tx_src_r[src_idx[2:0]];
        end else begin
          unique case (regs.reg_addr)
            MASTER_MODE_ADDR: rdata_r <= master_mode_r;
            STATUS_ADDR: rdata_r <= 8'(status_r[0]) << STAT_RX_MF_BIT |
                                    8'(status_r[1]) << STAT_TX_MF_BIT;
            RX_CTRL_ONE_ADDR: rdata_r <= rx_ctrl_r;
            TX_CTRL_ONE_ADDR: rdata_r <= tx_ctrl_r;
            TX_ALIGN_WORD_ADDR: rdata_r <= taf_r;
            TX_NONALIGN_WORD_ADDR: rdata_r <= tx_nonalign_frame_word_r;
            TX_INTL_ALIGN_ADDR: rdata_r <= si_af_r;
            TX_INTL_NONALIGN_ADDR: rdata_r <= si_naf_r;
            TX_REMOTE_ALARM_ADDR: rdata_r <= ra_r;
            TX_INSERT_CTRL_ADDR: rdata_r <= ins_ctrl_r;
            default: rdata_r <= REG_RESET;
          endcase
        end
      end
    end
  end

  assign regs.reg_rdata = rdata_r;
  assign regs.reg_rvalid = rvalid_r;
  assign master_mode_o = master_mode_r;
  assign rx_ctrl_one_o = rx_ctrl_r;
  assign tx_ctrl_one_o = tx_ctrl_r;
  assign tx_align_word_o = taf_r;
  assign tx_nonalign_word_o = tx_nonalign_frame_word_r;
endmodule

/* File: ssm_host_ctrl.sv */
// Host controller end: AXI4-Lite orders to framer register accesses
`timescale 1ns/10ps
module ssm_host_ctrl
  import ssm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  ssm_reg_if.host regs,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import ssm_pkg::*;

  ssm_host_state_type state_r;
  logic aw_got_r;
  logic w_got_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wr_fire;
  logic busy;
  logic done_r;
  logic [7:0] rd_byte_r;
  logic [2:0] step_r;
  logic [15:0] init_entry;
  logic [7:0] addr_r;
  logic [7:0] wdat_r;
  logic wr_r;
  logic rd_r;

  // Recommended E1 CRC4 set-up, one address and value per step
  always_comb begin
    unique case (step_r)
      3'd0: init_entry = {MASTER_MODE_ADDR, MASTER_MODE_E1};
      3'd1: init_entry = {RX_CTRL_ONE_ADDR, RX_CTRL_ONE_CRC4};
      3'd2: init_entry = {TX_CTRL_ONE_ADDR, TX_CTRL_ONE_CRC4};
      3'd3: init_entry = {TX_ALIGN_WORD_ADDR, TX_ALIGN_WORD_INIT};
      3'd4: init_entry = {TX_NONALIGN_WORD_ADDR, TX_NONALIGN_WORD_INIT};
      default: init_entry = {TX_INSERT_CTRL_ADDR, REG_RESET};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels

  assign busy = state_r != HST_IDLE;
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;

  // Address and data latch in either order; response after both
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == HOST_CMD_ADDR || awaddr_r == HOST_INIT_ADDR ||
                        awaddr_r == HOST_STAT_ADDR) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  assign s_axi_arready = !s_axi_rvalid;

  // Status word or zero with an error for unmapped addresses
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        if (s_axi_araddr == HOST_STAT_ADDR) begin
          s_axi_rdata <= 32'(rd_byte_r) | 32'(busy) << STAT_BUSY_BIT |
                         32'(done_r) << STAT_DONE_BIT;
          s_axi_rresp <= AXI_OKAY;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= (s_axi_araddr == HOST_CMD_ADDR ||
                          s_axi_araddr == HOST_INIT_ADDR) ? AXI_OKAY : AXI_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Framer access sequencer; orders that arrive while busy are dropped

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_r <= HST_IDLE;
      step_r <= 3'h0;
      addr_r <= 8'h00;
      wdat_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      done_r <= 1'b0;
      rd_byte_r <= 8'h00;
    end else if (ce_i) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      unique case (state_r)
        HST_IDLE: begin
          if (wr_fire && awaddr_r == HOST_CMD_ADDR && s_axi_wstrb != 4'h0) begin
            addr_r <= wdata_r[7:0];
            wdat_r <= wdata_r[CMD_WDATA_LSB +: 8];
            done_r <= 1'b0;
            if (wdata_r[CMD_WRITE_BIT]) begin
              wr_r <= 1'b1;
              done_r <= 1'b1;
            end else begin
              rd_r <= 1'b1;
              state_r <= HST_WAIT_RD;
            end
          end else if (wr_fire && awaddr_r == HOST_INIT_ADDR && wdata_r[0]) begin
            step_r <= 3'h0;
            done_r <= 1'b0;
            state_r <= HST_INIT;
          end
        end
        HST_WAIT_RD: begin
          if (regs.reg_rvalid) begin
            rd_byte_r <= regs.reg_rdata;
            done_r <= 1'b1;
            state_r <= HST_IDLE;
          end
        end
        HST_INIT: begin
          addr_r <= init_entry[15:8];
          wdat_r <= init_entry[7:0];
          wr_r <= 1'b1;
          step_r <= step_r + 3'h1;
          if (step_r == 3'(INIT_STEPS - 1)) begin
            done_r <= 1'b1;
            state_r <= HST_IDLE;
          end
        end
      endcase
    end
  end

  assign regs.reg_addr = addr_r;
  assign regs.reg_wdata = wdat_r;
  assign regs.reg_wr = wr_r;
  assign regs.reg_rd = rd_r;
endmodule

/* File: ssm_pkg.sv */
// Constants shared by the spare-bit framer end and its host controller end
package ssm_pkg;
  localparam int SA_N = 5;
  localparam int FRAMES = 16;
  // Device register offsets
  localparam logic [7:0] MASTER_MODE_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h1c;
  localparam logic [7:0] RX_CTRL_ONE_ADDR = 8'h33;
  localparam logic [7:0] TX_CTRL_ONE_ADDR = 8'h35;
  localparam logic [7:0] RX_CAPTURE_FIRST = 8'hcb;
  localparam logic [7:0] RX_CAPTURE_LAST = 8'hcf;
  localparam logic [7:0] TX_ALIGN_WORD_ADDR = 8'hd0;
  localparam logic [7:0] TX_NONALIGN_WORD_ADDR = 8'hd1;
  localparam logic [7:0] TX_INTL_ALIGN_ADDR = 8'hd2;
  localparam logic [7:0] TX_INTL_NONALIGN_ADDR = 8'hd3;
  localparam logic [7:0] TX_REMOTE_ALARM_ADDR = 8'hd4;
  localparam logic [7:0] TX_SOURCE_FIRST = 8'hd5;
  localparam logic [7:0] TX_SOURCE_LAST = 8'hd9;
  localparam logic [7:0] TX_INSERT_CTRL_ADDR = 8'hda;
  // Insertion-control and status fields
  localparam int INS_SA_MSB = 4;
  localparam int INS_RA_BIT = 5;
  localparam int INS_SI_NONALIGN_BIT = 6;
  localparam int INS_SI_ALIGN_BIT = 7;
  localparam int STAT_RX_MF_BIT = 1;
  localparam int STAT_TX_MF_BIT = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Recommended E1 CRC4 set-up values
  localparam logic [7:0] MASTER_MODE_E1 = 8'h02;
  localparam logic [7:0] RX_CTRL_ONE_CRC4 = 8'h48;
  localparam logic [7:0] TX_CTRL_ONE_CRC4 = 8'h11;
  localparam logic [7:0] TX_ALIGN_WORD_INIT = 8'h1b;
  localparam logic [7:0] TX_NONALIGN_WORD_INIT = 8'h40;
  localparam int INIT_STEPS = 6;
  // Host AXI4-Lite map
  localparam logic [3:0] HOST_CMD_ADDR = 4'h0;
  localparam logic [3:0] HOST_STAT_ADDR = 4'h4;
  localparam logic [3:0] HOST_INIT_ADDR = 4'h8;
  localparam int CMD_WDATA_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_DONE_BIT = 9;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    HST_IDLE,
    HST_WAIT_RD,
    HST_INIT
  } ssm_host_state_type;
endpackage

/* File: ssm_reg_if.sv */
// Register port joining the host controller to the spare-bit framer
`timescale 1ns/10ps
interface ssm_reg_if;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  modport device (input reg_addr, reg_wr, reg_rd, reg_wdata, output reg_rdata, reg_rvalid);
  modport host (output reg_addr, reg_wr, reg_rd, reg_wdata, input reg_rdata, reg_rvalid);
endinterface

/* File: tb.sv */
// Testbench joining host controller and framer end over the register port
`timescale 1ns/10ps
module tb;
  import ssm_pkg::*;
  logic clk_sys_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic ce_i = 1'h1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic rx_frame = 1'h0, rx_mf = 1'h0, tx_frame = 1'h0, tx_mf = 1'h0;
  logic [4:0] rx_sa = 5'h00, tx_sa, tx_sa_en;
  logic tx_si, tx_si_en, tx_ra, tx_ra_en, rx_flag, tx_flag;
  logic [7:0] mm, rc1, tc1, taw, tnaw;
  int mismatches = 0, n_checks = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  ssm_reg_if bus ();
  ssm_framer_dev i_ssm_framer_dev (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .regs(bus.device), .rx_frame_i(rx_frame), .rx_mf_start_i(rx_mf), .rx_sa_i(rx_sa),
    .tx_frame_i(tx_frame), .tx_mf_start_i(tx_mf), .tx_sa_o(tx_sa), .tx_sa_en_o(tx_sa_en),
    .tx_si_o(tx_si), .tx_si_en_o(tx_si_en), .tx_ra_o(tx_ra), .tx_ra_en_o(tx_ra_en),
    .rx_crc_multiframe_flag_o(rx_flag), .tx_multiframe_flag_o(tx_flag), .master_mode_o(mm),
    .rx_ctrl_one_o(rc1), .tx_ctrl_one_o(tc1), .tx_align_word_o(taw),
    .tx_nonalign_word_o(tnaw));
  ssm_host_ctrl i_ssm_host_ctrl (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .regs(bus.host), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ssm_chk_properties i_ssm_chk_properties (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_addr(bus.reg_addr), .reg_wr(bus.reg_wr), .reg_rd(bus.reg_rd),
    .reg_wdata(bus.reg_wdata), .reg_rdata(bus.reg_rdata), .reg_rvalid(bus.reg_rvalid),
    .rx_frame_i(rx_frame), .rx_mf_start_i(rx_mf), .tx_frame_i(tx_frame),
    .tx_mf_start_i(tx_mf), .rx_crc_multiframe_flag_o(rx_flag),
    .tx_multiframe_flag_o(tx_flag), .tx_sa_o(tx_sa), .tx_sa_en_o(tx_sa_en),
    .tx_si_en_o(tx_si_en), .tx_ra_en_o(tx_ra_en));
  //////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bus write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge clk_sys_i);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 1'h0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge clk_sys_i); while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask
  // Bus read
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk_sys_i); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk_sys_i); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  // Wait until the controller is no longer busy
  task automatic wait_idle(output logic [31:0] s);
    logic [1:0] r;
    s = 32'h100;
    while (s[STAT_BUSY_BIT] !== 1'h0) axi_rd(HOST_STAT_ADDR, s, r);
  endtask
  // One framer register access through the controller
  task automatic dev_op(input logic [7:0] a, input logic [7:0] d, input bit wr,
      output logic [7:0] q);
    logic [31:0] s;
    logic [1:0] r;
    axi_wr(HOST_CMD_ADDR, {15'h0, wr, d, a}, r);
    wait_idle(s);
    q = s[7:0];
  endtask
  // One frame pulse on the receive or transmit side
  task automatic line_frame(input bit rx, input bit mf, input logic [4:0] sa);
    @(posedge clk_sys_i);
    if (rx) begin
      rx_frame <= 1'h1;
      rx_mf <= mf;
      rx_sa <= sa;
    end else begin
      tx_frame <= 1'h1;
      tx_mf <= mf;
    end
    @(posedge clk_sys_i);
    rx_frame <= 1'h0;
    tx_frame <= 1'h0;
    @(posedge clk_sys_i);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Source registers read back; capture registers and unmapped places refuse
  task automatic t_regs();
    logic [7:0] q;
    logic [31:0] s;
    logic [1:0] r;
    for (int k = 0; k < 6; k++) dev_op(8'hd5 + 8'(k), 8'h3c ^ 8'(k * 17), 1, q);
    for (int k = 0; k < 6; k++) begin
      dev_op(8'hd5 + 8'(k), 8'h00, 0, q);
      chk("source readback", 8'h3c ^ 8'(k * 17), q);
    end
    dev_op(8'hcd, 8'h5a, 1, q);
    dev_op(8'hcd, 8'h00, 0, q);
    chk("capture after write", 8'h00, q);
    axi_rd(4'hc, s, r);
    chk("unmapped rresp", AXI_SLVERR, r);
  endtask
  // Recommended set-up sequence
  task automatic t_init();
    logic [31:0] s;
    logic [1:0] r;
    logic [7:0] q;
    axi_wr(HOST_INIT_ADDR, 32'h1, r);
    wait_idle(s);
    chk("master mode", 8'h02, mm);
    chk("rx ctrl one", 8'h48, rc1);
    chk("tx ctrl one", 8'h11, tc1);
    chk("align word", 8'h1b, taw);
    chk("nonalign word", 8'h40, tnaw);
    dev_op(TX_INSERT_CTRL_ADDR, 8'h00, 0, q);
    chk("insert ctrl", 8'h00, q);
  endtask
  // Receive a multiframe; odd frames carry the bits, even frames the inverse
  task automatic t_rx();
    logic [7:0] e [5] = '{8'h96, 8'h3c, 8'ha5, 8'h01, 8'h80};
    logic [4:0] sa;
    logic [7:0] q;
    for (int i = 0; i < 17; i++) begin
      for (int n = 0; n < 5; n++) sa[4 - n] = e[n][7 - (i % 16) / 2] ^ i[0];
      line_frame(1, i % 16 == 0, sa);
    end
    for (int n = 0; n < 5; n++) begin
      dev_op(RX_CAPTURE_FIRST + 8'(n), 8'h00, 0, q);
      chk("capture", e[n], q);
    end
    dev_op(STATUS_ADDR, 8'h00, 0, q);
    chk("rx status", 8'h02, q);
    line_frame(1, 0, 5'h1f);
    line_frame(1, 0, 5'h1f);
    dev_op(RX_CAPTURE_FIRST, 8'h00, 0, q);
    chk("capture mid multiframe", e[0], q);
  endtask
  // Send one multiframe and judge the Sa bits of every odd frame
  task automatic send_mf(input logic [7:0] v [5], input logic [7:0] ctrl, input bit upd);
    logic [4:0] ex;
    logic [7:0] q;
    for (int i = 0; i < 16; i++) begin
      line_frame(0, i == 0, 5'h00);
      for (int n = 0; n < 5; n++) ex[4 - n] = v[n][7 - i / 2];
      if (i % 2 == 0) begin
        chk("tx sa", ex, tx_sa);
        chk("tx sa en", ctrl[4:0], tx_sa_en);
        chk("tx ra", {v[3][7 - i / 2], ctrl[5]}, {tx_ra, tx_ra_en});
        chk("tx si nonalign", {v[2][7 - i / 2], ctrl[6]}, {tx_si, tx_si_en});
      end else begin
        chk("tx odd sa en ra", 7'h00, {tx_sa_en, tx_ra, tx_ra_en});
        chk("tx si align", {v[1][7 - i / 2], ctrl[7]}, {tx_si, tx_si_en});
      end
      if (upd && i == 4) dev_op(TX_SOURCE_FIRST, ~v[0], 1, q);
    end
  endtask
  // Mid-multiframe update is held back to the next boundary
  task automatic t_tx();
    logic [7:0] v [5] = '{8'hc3, 8'h5a, 8'h0f, 8'he1, 8'h96};
    logic [7:0] q;
    for (int n = 0; n < 5; n++) dev_op(TX_SOURCE_FIRST + 8'(n), v[n], 1, q);
    for (int n = 1; n < 4; n++) dev_op(TX_INTL_ALIGN_ADDR + 8'(n - 1), v[n], 1, q);
    dev_op(TX_INSERT_CTRL_ADDR, 8'h75, 1, q);
    send_mf(v, 8'h75, 1);
    v[0] = ~v[0];
    send_mf(v, 8'h75, 0);
    dev_op(TX_INSERT_CTRL_ADDR, 8'h8a, 1, q);
    send_mf(v, 8'h8a, 0);
  endtask
  // Counts and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    t_regs();
    t_init();
    t_rx();
    t_tx();
    wrap_up();
  end
  // Hang guard
  initial begin
    #3000000;
    mismatches++;
    wrap_up();
  end
endmodule
